// *** src/xiem_defines.vh ***
`ifndef XIEM_DEFINES_VH
`define XIEM_DEFINES_VH

// Register map
`define XIEM_ENABLE_ADDR 8'hE6
`define XIEM_ENABLE_RESET 8'h00
`define XIEM_DATA_W 8
`define XIEM_READ_IDLE 8'h00

// Field positions inside the enable register
`define XIEM_BIT_PORT_MATCH 7
`define XIEM_BIT_REG_DROPOUT 6
`define XIEM_BIT_LIN 5
`define XIEM_BIT_CMP_RISE 4
`define XIEM_BIT_CMP_FALL 3
`define XIEM_BIT_COUNTER_ARRAY 2
`define XIEM_BIT_CONV_DONE 1
`define XIEM_BIT_WINDOW_CMP 0

// Number of counter array request lines sharing one gate
`define XIEM_PCA_SRC_W 6
`define XIEM_PCA_IDLE 6'h00

`endif

// *** src/xiem_req_gate.v ***
`timescale 1ns/1ps
`default_nettype none
`include "xiem_defines.vh"

module xiem_req_gate (
    input wire sys_clk,
    input wire reset,
    input wire [`XIEM_DATA_W-1:0] req_vec,
    input wire [`XIEM_DATA_W-1:0] enable_vec,
    output reg [`XIEM_DATA_W-1:0] gated_vec
);

    // One register stage so every forwarded request leaves from a flip-flop
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            gated_vec <= `XIEM_ENABLE_RESET;
        end else begin
            gated_vec <= req_vec & enable_vec;
        end
    end

endmodule
`default_nettype wire

// *** src/xiem_enable_mask.v ***
`timescale 1ns/1ps
`default_nettype none
`include "xiem_defines.vh"

module xiem_enable_mask (
    input wire sys_clk,
    input wire reset,
    input wire [7:0] sfr_addr,
    input wire sfr_wr_en,
    input wire sfr_rd_en,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    input wire port_match_req,
    input wire regulator_dropout_req,
    input wire lin_controller_req,
    input wire comparator_rise_req,
    input wire comparator_fall_req,
    input wire [`XIEM_PCA_SRC_W-1:0] counter_array_req,
    input wire conversion_done_flag,
    input wire window_compare_req,
    output reg [`XIEM_DATA_W-1:0] extended_irq_enable_one,
    output wire port_match_irq,
    output wire regulator_dropout_irq,
    output wire lin_controller_irq,
    output wire comparator_rise_irq,
    output wire comparator_fall_irq,
    output wire counter_array_irq,
    output wire conversion_done_irq,
    output wire window_compare_irq
);

    wire addr_hit;
    wire [`XIEM_DATA_W-1:0] req_vec;
    wire [`XIEM_DATA_W-1:0] enable_vec;
    wire [`XIEM_DATA_W-1:0] gated_vec;

    // Named views of the enable fields
    wire port_match_irq_enable;
    wire regulator_dropout_irq_enable;
    wire lin_controller_irq_enable;
    wire comparator_rise_irq_enable;
    wire comparator_fall_irq_enable;
    wire counter_array_irq_enable;
    wire conversion_done_irq_enable;
    wire window_compare_irq_enable;

    assign addr_hit = (sfr_addr == `XIEM_ENABLE_ADDR);

    assign port_match_irq_enable = extended_irq_enable_one[`XIEM_BIT_PORT_MATCH];
    assign regulator_dropout_irq_enable = extended_irq_enable_one[`XIEM_BIT_REG_DROPOUT];
    assign lin_controller_irq_enable = extended_irq_enable_one[`XIEM_BIT_LIN];
    assign comparator_rise_irq_enable = extended_irq_enable_one[`XIEM_BIT_CMP_RISE];
    assign comparator_fall_irq_enable = extended_irq_enable_one[`XIEM_BIT_CMP_FALL];
    assign counter_array_irq_enable = extended_irq_enable_one[`XIEM_BIT_COUNTER_ARRAY];
    assign conversion_done_irq_enable = extended_irq_enable_one[`XIEM_BIT_CONV_DONE];
    assign window_compare_irq_enable = extended_irq_enable_one[`XIEM_BIT_WINDOW_CMP];

    // Enable register; all sources start masked
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            extended_irq_enable_one <= `XIEM_ENABLE_RESET;
        end else if (sfr_wr_en && addr_hit) begin
            extended_irq_enable_one <= sfr_wdata;
        end
    end

    // Registered read; other addresses belong to other blocks, so answer zero
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sfr_rdata <= `XIEM_READ_IDLE;
        end else if (sfr_rd_en && addr_hit) begin
            sfr_rdata <= extended_irq_enable_one;
        end else begin
            sfr_rdata <= `XIEM_READ_IDLE;
        end
    end

    // Request vector in register bit order; sources are same-clock logic
    assign req_vec[`XIEM_BIT_PORT_MATCH] = port_match_req;
    assign req_vec[`XIEM_BIT_REG_DROPOUT] = regulator_dropout_req;
    assign req_vec[`XIEM_BIT_LIN] = lin_controller_req;
    assign req_vec[`XIEM_BIT_CMP_RISE] = comparator_rise_req;
    assign req_vec[`XIEM_BIT_CMP_FALL] = comparator_fall_req;
    // Any counter array line shares the one gate
    assign req_vec[`XIEM_BIT_COUNTER_ARRAY] = |counter_array_req;
    assign req_vec[`XIEM_BIT_CONV_DONE] = conversion_done_flag;
    assign req_vec[`XIEM_BIT_WINDOW_CMP] = window_compare_req;

    // Enable vector rebuilt from the named fields, so each gate reads its own field
    assign enable_vec[`XIEM_BIT_PORT_MATCH] = port_match_irq_enable;
    assign enable_vec[`XIEM_BIT_REG_DROPOUT] = regulator_dropout_irq_enable;
    assign enable_vec[`XIEM_BIT_LIN] = lin_controller_irq_enable;
    assign enable_vec[`XIEM_BIT_CMP_RISE] = comparator_rise_irq_enable;
    assign enable_vec[`XIEM_BIT_CMP_FALL] = comparator_fall_irq_enable;
    assign enable_vec[`XIEM_BIT_COUNTER_ARRAY] = counter_array_irq_enable;
    assign enable_vec[`XIEM_BIT_CONV_DONE] = conversion_done_irq_enable;
    assign enable_vec[`XIEM_BIT_WINDOW_CMP] = window_compare_irq_enable;

    // Gating is a pure AND; source flags are only read, never cleared here
    xiem_req_gate u_gate (
        .sys_clk(sys_clk),
        .reset(reset),
        .req_vec(req_vec),
        .enable_vec(enable_vec),
        .gated_vec(gated_vec)
    );

    // Forwarded requests, each straight from a gate flip-flop
    assign port_match_irq = gated_vec[`XIEM_BIT_PORT_MATCH];
    assign regulator_dropout_irq = gated_vec[`XIEM_BIT_REG_DROPOUT];
    assign lin_controller_irq = gated_vec[`XIEM_BIT_LIN];
    assign comparator_rise_irq = gated_vec[`XIEM_BIT_CMP_RISE];
    assign comparator_fall_irq = gated_vec[`XIEM_BIT_CMP_FALL];
    assign counter_array_irq = gated_vec[`XIEM_BIT_COUNTER_ARRAY];
    assign conversion_done_irq = gated_vec[`XIEM_BIT_CONV_DONE];
    assign window_compare_irq = gated_vec[`XIEM_BIT_WINDOW_CMP];

endmodule
`default_nettype wire

// *** sim/xiem_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module xiem_properties (
    input wire logic sys_clk, reset, sfr_wr_en, sfr_rd_en,
    input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, extended_irq_enable_one,
    input wire logic port_match_req, regulator_dropout_req, lin_controller_req,
    input wire logic comparator_rise_req, comparator_fall_req, conversion_done_flag,
    input wire logic window_compare_req, port_match_irq, regulator_dropout_irq,
    input wire logic lin_controller_irq, comparator_rise_irq, comparator_fall_irq,
    input wire logic counter_array_irq, conversion_done_irq, window_compare_irq,
    input wire logic [5:0] counter_array_req
);
    // Requests and forwarded outputs in mask bit order
    wire [7:0] m = extended_irq_enable_one;
    wire [7:0] q = {port_match_req, regulator_dropout_req, lin_controller_req,
        comparator_rise_req, comparator_fall_req, |counter_array_req,
        conversion_done_flag, window_compare_req};
    wire [7:0] o = {port_match_irq, regulator_dropout_irq, lin_controller_irq,
        comparator_rise_irq, comparator_fall_irq, counter_array_irq,
        conversion_done_irq, window_compare_irq};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Each output is one flop behind request and mask
    property p_b7; o[7] == $past(q[7] & m[7]); endproperty
    a_b7: assert property (p_b7) else $error("gate 7 wrong");
    property p_b6; o[6] == $past(q[6] & m[6]); endproperty
    a_b6: assert property (p_b6) else $error("gate 6 wrong");
    property p_b5; o[5] == $past(q[5] & m[5]); endproperty
    a_b5: assert property (p_b5) else $error("gate 5 wrong");
    property p_b4; o[4] == $past(q[4] & m[4]); endproperty
    a_b4: assert property (p_b4) else $error("gate 4 wrong");
    property p_b3; o[3] == $past(q[3] & m[3]); endproperty
    a_b3: assert property (p_b3) else $error("gate 3 wrong");
    property p_b2; o[2] == $past(q[2] & m[2]); endproperty
    a_b2: assert property (p_b2) else $error("gate 2 wrong");
    property p_b1; o[1] == $past(q[1] & m[1]); endproperty
    a_b1: assert property (p_b1) else $error("gate 1 wrong");
    property p_b0; o[0] == $past(q[0] & m[0]); endproperty
    a_b0: assert property (p_b0) else $error("gate 0 wrong");
    // Mask must read zero on the first edge after reset is let go
    property p_clear; $fell(reset) |-> m == 8'h00; endproperty
    a_clear: assert property (p_clear) else $error("mask not clear after reset");
endmodule
`default_nettype wire

// *** sim/xiem_sources.sv ***
`timescale 1ns/1ps
`default_nettype none
module xiem_sources (
    input wire logic sys_clk,
    output logic [13:0] req
);
    // Flags move just after each edge; bit 2 is spare
    initial req = 14'h0000;
    always @(posedge sys_clk) req <= #1 14'($urandom);
endmodule
`default_nettype wire

// *** sim/test_xiem_enable_mask.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_xiem_enable_mask;
    logic sys_clk = 0, reset = 1, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, mask = 8'h00, rdata, mreg, nm;
    wire [7:0] irq;
    logic [13:0] req;
    logic [23:0] nq[$];
    logic [23:0] e;
    int err_count = 0, checks = 0;
    wire [7:0] q = {req[7:3], |req[13:8], req[1:0]};
    always #12.5 sys_clk = ~sys_clk;
    xiem_sources u_src (.sys_clk(sys_clk), .req(req));
    xiem_enable_mask u_dut (.sys_clk(sys_clk), .reset(reset), .sfr_addr(addr),
        .sfr_wr_en(wr), .sfr_rd_en(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
        .port_match_req(req[7]), .regulator_dropout_req(req[6]), .lin_controller_req(req[5]),
        .comparator_rise_req(req[4]), .comparator_fall_req(req[3]),
        .counter_array_req(req[13:8]), .conversion_done_flag(req[1]),
        .window_compare_req(req[0]), .extended_irq_enable_one(mreg),
        .port_match_irq(irq[7]), .regulator_dropout_irq(irq[6]), .lin_controller_irq(irq[5]),
        .comparator_rise_irq(irq[4]), .comparator_fall_irq(irq[3]),
        .counter_array_irq(irq[2]), .conversion_done_irq(irq[1]), .window_compare_irq(irq[0]));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task results;
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One register cycle, then one idle edge before the next
    task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 wr = w; rd = r; addr = a; wdata = d;
        @(posedge sys_clk);
        #1 wr = 0; rd = 0;
    endtask
    // Notes what each edge should produce; gating uses the mask before the edge
    always @(posedge sys_clk) begin
        if (reset) begin
            mask = 8'h00;
            nq.delete();
        end else begin
            nm = (wr && addr == 8'hE6) ? wdata : mask;
            nq.push_back({q & mask, (rd && addr == 8'hE6) ? mask : 8'h00, nm});
            mask = nm;
        end
    end
    // Outputs are settled by the falling edge
    always @(negedge sys_clk) if (!reset && nq.size() > 0) begin
        e = nq.pop_front();
        check(irq, e[23:16]);
        check(rdata, e[15:8]);
        check(mreg, e[7:0]);
    end
    initial begin
        #100000 err_count++;
        results();
    end
    initial begin
        void'($urandom(65586));
        repeat (5) @(posedge sys_clk);
        #1 reset = 0;
        // One bit alone per pass, then random masks; stray writes must be ignored
        for (int i = 0; i < 12; i++) begin
            acc(1, 0, 8'hE6, (i < 8) ? 8'(1 << i) : 8'($urandom));
            acc(1, 1, 8'hE6, 8'($urandom));
            acc(1, 1, 8'hE7, ~mask);
            acc(0, 1, 8'hE5, 8'h00);
            repeat (12) @(posedge sys_clk);
        end
        #1 reset = 1;
        repeat (2) @(posedge sys_clk);
        #1 reset = 0;
        repeat (4) @(posedge sys_clk);
        results();
    end
endmodule
bind xiem_enable_mask xiem_properties u_prop (.*);
`default_nettype wire
